/* logic/monitor_adc.sv */
// Purpose: Round-robin converter sequencer with dual-range receive power
// Assumes: Converter handshake on core_clk, comparators arrive from pins
// Notes: Register port is the byte interface behind the serial slave

// Functional notes
// - Quick-trip flags low receive power per channel
// - Quick-trip result may drive loss output
// - One converter visits four channels in order
// - Full pass within period, then restart
// - Offset on all channels, gain on voltages
// - Receive channels shift right zero to seven
// - Each receive channel has 3-bit shift field
// - Shift every receive conversion before compare and store
// - Compare result with alarm and warning thresholds
// - Mask bits block fault, flags still set
// - Receive slot starts with fine conversion
// - Too large fine result triggers coarse conversion
// - Same result register for either range
// - Status bit shows fine or coarse result
// - Force bits override automatic range choice
// - Both force bits zero means dual range
// - Force fine alone disables dual range
// - Fine crossover caps pre-shift fine result
// - Coarse crossover floors pre-shift coarse result in dual range only
// - Separate fine and coarse gain registers
// - Separate fine and coarse offset registers
// - Quick-trip alarm held until sample clears
// - Without crossover, limits follow shift count
module monitor_adc #(
    parameter int RR_CYCLES = monitor_pkg::RR_CYCLES,
    parameter int QT_CYCLES = monitor_pkg::QT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic adc_start,
    output logic [1:0] adc_sel,
    output logic adc_coarse,
    input wire logic adc_done,
    input wire logic [15:0] adc_data,
    input wire logic low_power_trip_one,
    input wire logic low_power_trip_two,
    input wire logic rx_loss_in_one,
    input wire logic rx_loss_in_two,
    output logic [7:0] qt_level_one,
    output logic [7:0] qt_level_two,
    output logic rx_loss_output,
    output logic fault
);
    localparam int SLOT_CYCLES = RR_CYCLES / monitor_pkg::NUM_CH;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] cfg_r [0:127];
    logic [15:0] meas_r [0:3];
    logic [15:0] flags_r;
    logic [7:0] status_r;
    logic [1:0] qt_flag_r;
    logic [1:0] chan_r;
    monitor_pkg::seq_e state_r;
    logic coarse_r;
    logic [15:0] raw_r;
    logic [15:0] slot_cnt_r;
    logic [15:0] qt_cnt_r;
    logic slot_tick;
    logic qt_tick;
    logic [3:0] sync1_r, sync2_r, sync3_r, filt_r;

    function automatic logic [7:0] cfg_default(input int idx);
        logic [7:0] a;
        a = 8'(idx + 128);
        if (a == monitor_pkg::CH1_FG || a == monitor_pkg::CH1_CG ||
            a == monitor_pkg::CH2_FG || a == monitor_pkg::CH2_CG ||
            a == monitor_pkg::VCC_GAIN) begin
            return monitor_pkg::GAIN_UNITY[15:8];
        end
        if (a == monitor_pkg::MASK_OFF || a == monitor_pkg::MASK_OFF + 8'h01) begin
            return monitor_pkg::MASK_RESET;
        end
        return 8'h00;
    endfunction

    function automatic logic [15:0] word16(input logic [7:0] a);
        return {cfg_r[a[6:0]], cfg_r[7'(a[6:0] + 7'h01)]};
    endfunction

    // ----------------------------------------
    // Host register writes
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 128; i++) begin
            if (!reset_n) begin
                cfg_r[i] <= cfg_default(i);
            end else if (reg_wr && reg_addr[7] && reg_addr[6:0] == 7'(i)) begin
                cfg_r[i] <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // Channel decode and calibration
    // ----------------------------------------
    logic is_rx, is_rx2, force_fine, force_coarse, auto_rng, crossover_limit_en;
    logic [2:0] shift_n;
    logic [15:0] gain, offset, xf, xc;
    logic [31:0] prod;
    logic [17:0] sum;
    logic [15:0] cal_pre, pre_lim, final_val, floor_val;
    logic too_big;

    assign is_rx = chan_r[1];
    assign is_rx2 = chan_r == monitor_pkg::CH_RX2;
    assign crossover_limit_en = cfg_r[monitor_pkg::LOSS_CFG[6:0]][monitor_pkg::CROSSOVER_LIMIT_EN_BIT];
    assign shift_n = is_rx2 ? cfg_r[7'(monitor_pkg::SHIFT_OFF[6:0] + 7'h01)][2:0]
                            : cfg_r[monitor_pkg::SHIFT_OFF[6:0]][2:0];
    assign xf = is_rx2 ? word16(monitor_pkg::CH2_XF) : word16(monitor_pkg::CH1_XF);
    assign xc = is_rx2 ? word16(monitor_pkg::CH2_XC) : word16(monitor_pkg::CH1_XC);

    always_comb begin
        logic [7:0] fr;
        fr = cfg_r[monitor_pkg::FORCE_OFF[6:0]];
        force_coarse = is_rx && (is_rx2 ? fr[monitor_pkg::FC2_BIT] : fr[monitor_pkg::FC1_BIT]);
        force_fine = is_rx && !force_coarse &&
            (is_rx2 ? fr[monitor_pkg::FF2_BIT] : fr[monitor_pkg::FF1_BIT]);
        auto_rng = is_rx && !force_coarse && !force_fine;
    end

    always_comb begin
        case (chan_r)
            monitor_pkg::CH_TEMP: begin
                gain = monitor_pkg::GAIN_UNITY;
                offset = word16(monitor_pkg::TEMP_OFS);
            end
            monitor_pkg::CH_VCC: begin
                gain = word16(monitor_pkg::VCC_GAIN);
                offset = word16(monitor_pkg::VCC_OFS);
            end
            monitor_pkg::CH_RX1: begin
                gain = coarse_r ? word16(monitor_pkg::CH1_CG) : word16(monitor_pkg::CH1_FG);
                offset = coarse_r ? word16(monitor_pkg::CH1_CO) : word16(monitor_pkg::CH1_FO);
            end
            default: begin
                gain = coarse_r ? word16(monitor_pkg::CH2_CG) : word16(monitor_pkg::CH2_FG);
                offset = coarse_r ? word16(monitor_pkg::CH2_CO) : word16(monitor_pkg::CH2_FO);
            end
        endcase
    end

    // Saturate rather than wrap so a hot input never reads as a small value
    assign prod = raw_r * gain;
    assign sum = {1'b0, prod[31:monitor_pkg::GAIN_FRAC]} + {2'b00, offset};
    assign cal_pre = |sum[17:16] ? 16'hffff : sum[15:0];
    assign too_big = crossover_limit_en ? (cal_pre > xf) : (cal_pre >= monitor_pkg::FINE_FULL);
    assign floor_val = monitor_pkg::COARSE_FLOOR >> shift_n;

    always_comb begin
        pre_lim = cal_pre;
        if (is_rx && crossover_limit_en && !coarse_r && cal_pre > xf) begin
            pre_lim = xf;
        end
        if (is_rx && crossover_limit_en && coarse_r && auto_rng && cal_pre < xc) begin
            pre_lim = xc;
        end
        final_val = is_rx ? (pre_lim >> shift_n) : pre_lim;
        if (is_rx && !crossover_limit_en && coarse_r && auto_rng && final_val < floor_val) begin
            final_val = floor_val;
        end
    end

    // ----------------------------------------
    // Slot and quick-trip dividers
    // ----------------------------------------
    assign slot_tick = slot_cnt_r == 16'(SLOT_CYCLES - 1);
    assign qt_tick = qt_cnt_r == 16'(QT_CYCLES - 1);

    always_ff @(posedge core_clk) begin
        if (!reset_n || slot_tick) begin
            slot_cnt_r <= 16'h0000;
        end else begin
            slot_cnt_r <= slot_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n || qt_tick) begin
            qt_cnt_r <= 16'h0000;
        end else begin
            qt_cnt_r <= qt_cnt_r + 16'h0001;
        end
    end

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    // A slot boundary restarts the sequence, so a lost done cannot hang it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_r <= monitor_pkg::S_IDLE;
            chan_r <= monitor_pkg::CH_RX2;
            coarse_r <= 1'b0;
            raw_r <= 16'h0000;
        end else if (slot_tick) begin
            chan_r <= 2'(chan_r + 2'h1);
            coarse_r <= 1'b0;
            state_r <= monitor_pkg::S_FINE;
        end else begin
            case (state_r)
                monitor_pkg::S_IDLE: state_r <= monitor_pkg::S_IDLE;
                monitor_pkg::S_FINE: begin
                    coarse_r <= force_coarse;
                    state_r <= monitor_pkg::S_WFINE;
                end
                monitor_pkg::S_WFINE: begin
                    if (adc_done) begin
                        raw_r <= adc_data;
                        state_r <= monitor_pkg::S_FCHK;
                    end
                end
                monitor_pkg::S_FCHK: begin
                    if (!coarse_r && auto_rng && too_big) begin
                        coarse_r <= 1'b1;
                        state_r <= monitor_pkg::S_COARSE;
                    end else begin
                        state_r <= monitor_pkg::S_STORE;
                    end
                end
                monitor_pkg::S_COARSE: state_r <= monitor_pkg::S_WCOARSE;
                monitor_pkg::S_WCOARSE: begin
                    if (adc_done) begin
                        raw_r <= adc_data;
                        state_r <= monitor_pkg::S_STORE;
                    end
                end
                monitor_pkg::S_STORE: state_r <= monitor_pkg::S_IDLE;
                default: state_r <= monitor_pkg::S_IDLE;
            endcase
        end
    end

    // The front end sees the range request during the start pulse
    assign adc_start = (state_r == monitor_pkg::S_COARSE) ||
                       (state_r == monitor_pkg::S_FINE && !slot_tick);
    assign adc_sel = chan_r;
    assign adc_coarse = (state_r == monitor_pkg::S_FINE) ? force_coarse : coarse_r;

    // ----------------------------------------
    // Results, alarms and status
    // ----------------------------------------
    logic store;
    logic [3:0] alarm_bits;
    logic [7:0] tb;

    assign store = state_r == monitor_pkg::S_STORE && !slot_tick;
    assign tb = 8'(monitor_pkg::THR_BASE + {3'h0, chan_r, 3'h0});
    // Bit order: high alarm, low alarm, high warning, low warning
    assign alarm_bits = {final_val < word16(8'(tb + 8'h06)), final_val > word16(8'(tb + 8'h04)),
                         final_val < word16(8'(tb + 8'h02)), final_val > word16(tb)};

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                meas_r[i] <= 16'h0000;
            end
            flags_r <= 16'h0000;
        end else if (store) begin
            meas_r[chan_r] <= final_val;
            flags_r[{chan_r, 2'h0} +: 4] <= alarm_bits;
        end
    end

    // New-result bits are write-one-to-clear; a fresh result wins the clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status_r <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == monitor_pkg::STATUS_OFF) begin
                status_r[3:0] <= status_r[3:0] & ~reg_wdata[3:0];
            end
            if (store) begin
                status_r[chan_r] <= 1'b1;
                if (chan_r == monitor_pkg::CH_RX1) begin
                    status_r[monitor_pkg::RANGE1_BIT] <= coarse_r;
                end
                if (is_rx2) begin
                    status_r[monitor_pkg::RANGE2_BIT] <= coarse_r;
                end
            end
        end
    end

    // ----------------------------------------
    // Quick trip and loss output
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            sync3_r <= 4'h0;
            filt_r <= 4'h0;
        end else begin
            sync1_r <= {rx_loss_in_two, rx_loss_in_one, low_power_trip_two, low_power_trip_one};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (int i = 0; i < 4; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    filt_r[i] <= sync3_r[i];
                end
            end
        end
    end

    // Polled comparator: a trip holds until a later sample reads clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            qt_flag_r <= 2'h0;
        end else if (qt_tick) begin
            qt_flag_r <= filt_r[1:0];
        end
    end

    logic [7:0] loss_cfg;
    logic [1:0] qt_en;
    assign loss_cfg = cfg_r[monitor_pkg::LOSS_CFG[6:0]];
    assign qt_en = ~{loss_cfg[monitor_pkg::QT_MASK2_BIT], loss_cfg[monitor_pkg::QT_MASK1_BIT]};

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rx_loss_output <= 1'b0;
            fault <= 1'b0;
            qt_level_one <= 8'h00;
            qt_level_two <= 8'h00;
        end else begin
            rx_loss_output <= loss_cfg[monitor_pkg::LOSS_SEL_BIT] ? |qt_flag_r
                                                                : |filt_r[3:2];
            fault <= |(flags_r & ~word16(monitor_pkg::MASK_OFF)) | |(qt_flag_r & qt_en);
            qt_level_one <= cfg_r[monitor_pkg::QT_THR1[6:0]];
            qt_level_two <= cfg_r[monitor_pkg::QT_THR2[6:0]];
        end
    end

    // ----------------------------------------
    // Host register reads
    // ----------------------------------------
    logic [7:0] rd_val;
    always_comb begin
        logic [7:0] m;
        m = 8'(reg_addr - monitor_pkg::MEAS_BASE);
        rd_val = 8'h00;
        if (reg_addr[7]) begin
            rd_val = cfg_r[reg_addr[6:0]];
        end else if (reg_addr >= monitor_pkg::MEAS_BASE && reg_addr <= monitor_pkg::MEAS_LAST) begin
            rd_val = m[0] ? meas_r[m[2:1]][7:0] : meas_r[m[2:1]][15:8];
        end else if (reg_addr == monitor_pkg::STATUS_OFF) begin
            rd_val = status_r;
        end else if (reg_addr == monitor_pkg::FLAGS_OFF) begin
            rd_val = flags_r[15:8];
        end else if (reg_addr == 8'(monitor_pkg::FLAGS_OFF + 8'h01)) begin
            rd_val = flags_r[7:0];
        end else if (reg_addr == monitor_pkg::QT_FLAG_OFF) begin
            rd_val = {6'h00, qt_flag_r};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_val;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    rr_order_a: assert property (slot_tick |=> chan_r == 2'($past(chan_r) + 2'h1))
        else $error("channel order broken");
    rr_wrap_a: assert property (slot_tick && is_rx2 |=> chan_r == monitor_pkg::CH_TEMP
        && state_r == monitor_pkg::S_FINE) else $error("pass did not restart");
    shift_bound_a: assert property (store && is_rx && !coarse_r
        |-> final_val <= (16'hffff >> shift_n)) else $error("shift not applied");
    alarm_cmp_a: assert property (store
        |=> flags_r[{$past(chan_r), 2'h0}] == ($past(final_val) > $past(word16(tb))))
        else $error("high alarm flag wrong");
    fault_mask_a: assert property ((word16(monitor_pkg::MASK_OFF) == 16'hffff
        && qt_en == 2'h0) [*2] |-> !fault) else $error("masked flag drove fault");
    force_fine_a: assert property (state_r == monitor_pkg::S_FCHK && force_fine
        |=> state_r != monitor_pkg::S_COARSE) else $error("forced fine went coarse");
    auto_coarse_a: assert property (state_r == monitor_pkg::S_FCHK && !slot_tick
        && auto_rng && !coarse_r && too_big |=> state_r == monitor_pkg::S_COARSE && coarse_r)
        else $error("no coarse after overrange");
    range_flag_a: assert property (store && is_rx2
        |=> status_r[monitor_pkg::RANGE2_BIT] == $past(coarse_r)) else $error("range bit");
    coarse_min_a: assert property (store && coarse_r && auto_rng && crossover_limit_en
        |-> pre_lim >= xc) else $error("coarse below crossover");
    qt_hold_a: assert property (!qt_tick |=> $stable(qt_flag_r))
        else $error("trip flag moved off sample");

    coarse_c: cover property (state_r == monitor_pkg::S_WCOARSE && adc_done);
    pass_c: cover property (slot_tick && is_rx2);
    loss_c: cover property ($rose(rx_loss_output));
    fault_c: cover property ($rose(fault));
endmodule

/* logic/monitor_pkg.sv */
// Purpose: Shared constants for the monitor converter sequencer
// Assumes: 100 MHz core clock, byte-wide register port
// Notes: Multi-byte registers are most significant byte first
package monitor_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RR_TIME_US = 80;
    localparam int RR_CYCLES = RR_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int QT_TIME_NS = 160;
    localparam int QT_CYCLES = QT_TIME_NS / CLK_PERIOD_NS;
    localparam int NUM_CH = 4;
    // ----------------------------------------
    // Channels and sequencer states
    // ----------------------------------------
    localparam logic [1:0] CH_TEMP = 2'h0;
    localparam logic [1:0] CH_VCC = 2'h1;
    localparam logic [1:0] CH_RX1 = 2'h2;
    localparam logic [1:0] CH_RX2 = 2'h3;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_FINE = 3'h1, S_WFINE = 3'h3, S_FCHK = 3'h2,
        S_COARSE = 3'h6, S_WCOARSE = 3'h7, S_STORE = 3'h5
    } seq_e;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] MEAS_BASE = 8'h64;
    localparam logic [7:0] MEAS_LAST = 8'h6b;
    localparam logic [7:0] STATUS_OFF = 8'h6f;
    localparam logic [7:0] FLAGS_OFF = 8'h70;
    localparam logic [7:0] QT_FLAG_OFF = 8'h72;
    localparam logic [7:0] FORCE_OFF = 8'h8d;
    localparam logic [7:0] SHIFT_OFF = 8'h8e;
    localparam logic [7:0] CH2_XC = 8'h94, CH2_XF = 8'h96, CH2_CG = 8'h98, CH2_FG = 8'h9a;
    localparam logic [7:0] CH1_CG = 8'h9c, CH1_FG = 8'h9e, CH1_XC = 8'ha4, CH1_XF = 8'ha6;
    localparam logic [7:0] CH2_CO = 8'ha8, CH2_FO = 8'haa, CH1_CO = 8'hac, CH1_FO = 8'hae;
    localparam logic [7:0] TEMP_OFS = 8'hb0, VCC_GAIN = 8'hb2, VCC_OFS = 8'hb4;
    localparam logic [7:0] THR_BASE = 8'hc0;
    localparam logic [7:0] MASK_OFF = 8'he0;
    localparam logic [7:0] LOSS_CFG = 8'he2;
    localparam logic [7:0] QT_THR1 = 8'he3, QT_THR2 = 8'he4;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int FF1_BIT = 0, FC1_BIT = 1, FF2_BIT = 2, FC2_BIT = 3;
    localparam int RANGE1_BIT = 4, RANGE2_BIT = 5;
    localparam int LOSS_SEL_BIT = 0, CROSSOVER_LIMIT_EN_BIT = 1, QT_MASK1_BIT = 2, QT_MASK2_BIT = 3;
    localparam logic [15:0] GAIN_UNITY = 16'h8000;
    localparam int GAIN_FRAC = 15;
    localparam logic [15:0] OFFSET_DEFAULT = 16'h0000;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [15:0] FINE_FULL = 16'hfff8;
    localparam logic [15:0] COARSE_FLOOR = 16'hf000;
endpackage

/* bench/adc_model.sv */
// Purpose: Converter model answering the sequencer start pulses
// Assumes: Latency of 1 to 4 cycles set by the bench
// Notes: Data is scrambled outside the done cycle
module adc_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic adc_start,
    input wire logic adc_coarse,
    input wire logic [15:0] fine_code,
    input wire logic [15:0] coarse_code,
    input wire logic [2:0] latency,
    output logic adc_done,
    output logic [15:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_r, rng_r;
    logic [2:0] cnt_r;
    always_ff @(posedge core_clk) begin
        adc_done <= 1'b0;
        cnt_r <= cnt_r - 3'h1;
        // Never leave the last code up, so a late sample cannot pass by luck
        adc_data <= ~adc_data;
        if (!reset_n) begin
            busy_r <= 1'b0;
            adc_data <= 16'h5a5a;
        end else if (adc_start) begin
            busy_r <= 1'b1;
            rng_r <= adc_coarse;
            cnt_r <= latency;
        end else if (busy_r && cnt_r == 3'h1) begin
            busy_r <= 1'b0;
            adc_done <= 1'b1;
            adc_data <= rng_r ? coarse_code : fine_code;
        end
    end
endmodule

/* bench/test_monitor_adc.sv */
// Purpose: Self-checking bench for the monitor converter sequencer
// Assumes: Short round-robin and quick-trip counts keep the run brief
// Notes: Register reads queue an expectation that a monitor compares
module test_monitor_adc;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RR = 64;
    logic core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, q1, q2, m;
    logic adc_start, adc_coarse, adc_done, rx_loss_output, fault;
    logic low_power_trip_one = 1'b0, low_power_trip_two = 1'b0;
    logic rx_loss_in_one = 1'b0, rx_loss_in_two = 1'b0;
    logic [1:0] adc_sel, last_sel = 2'h3;
    logic [15:0] adc_data, fine_code = 16'h0, coarse_code = 16'h0, f, c, n;
    logic [2:0] latency = 3'h2, s = 3'h0;
    logic [15:0] exp_q[$];
    logic [7:0] msk_q[$];
    int n_mismatch = 0, cmp_count = 0, cyc = 0, t_temp = 0;
    always #5 core_clk = ~core_clk;
    monitor_adc #(.RR_CYCLES(RR), .QT_CYCLES(4)) u_monitor_adc (.core_clk(core_clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_start(adc_start), .adc_sel(adc_sel),
        .adc_coarse(adc_coarse), .adc_done(adc_done), .adc_data(adc_data),
        .low_power_trip_one(low_power_trip_one), .low_power_trip_two(low_power_trip_two),
        .rx_loss_in_one(rx_loss_in_one), .rx_loss_in_two(rx_loss_in_two),
        .qt_level_one(q1), .qt_level_two(q2), .rx_loss_output(rx_loss_output), .fault(fault));
    adc_model u_adc_model (.core_clk(core_clk), .reset_n(reset_n), .adc_start(adc_start),
        .adc_coarse(adc_coarse), .fine_code(fine_code), .coarse_code(coarse_code),
        .latency(latency), .adc_done(adc_done), .adc_data(adc_data));
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] e);
        cmp_count++;
        if (seen !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, e, seen);
        end
    endtask
    task automatic wrap_up();
        $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 8'h1, d[7:0]);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back({a, e});
        msk_q.push_back(mk);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    // Result pair plus the range flag; no snapshot, so codes stay fixed meanwhile
    task automatic chk_rx(input logic [15:0] e, input logic crs);
        rd(8'h68, e[15:8], 8'hff);
        rd(8'h69, e[7:0], 8'hff);
        rd(8'h6f, {3'h0, crs, 4'h0}, 8'h10);
    endtask
    task automatic conv(input logic [15:0] fc, input logic [15:0] cc);
        @(posedge core_clk);
        fine_code <= fc;
        coarse_code <= cc;
        latency <= 3'(1 + $urandom % 4);
        repeat (2 * RR + 8) @(posedge core_clk);
    endtask
    function automatic logic [15:0] cal(input logic [15:0] raw, input logic [15:0] g,
        input logic [15:0] o, input logic [15:0] lo);
        logic [31:0] v;
        v = ((32'(raw) * 32'(g)) >> 15) + 32'(o);
        if (v > 32'hffff) v = 32'hffff;
        if (v < 32'(lo)) v = 32'(lo);
        return v[15:0] >> s;
    endfunction
    always @(posedge core_clk) rd_pend <= reg_rd;
    always @(negedge core_clk) begin
        if (rd_pend) begin
            n = exp_q.pop_front();
            m = msk_q.pop_front();
            check($sformatf("reg %h", n[15:8]), {8'h0, reg_rdata & m}, {8'h0, n[7:0] & m});
        end
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
        if (reset_n && adc_start && adc_sel !== last_sel) begin
            check("channel", {14'h0, adc_sel}, {14'h0, 2'(last_sel + 2'h1)});
            last_sel <= adc_sel;
            if (adc_sel == 2'h0 && t_temp != 0) check("round", 16'(cyc - t_temp), 16'(RR));
            if (adc_sel == 2'h0) t_temp <= cyc;
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'h267c));
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(8'h9e, 8'h80, 8'hff);
        rd(8'h8d, 8'h00, 8'hff);
        rd(8'he0, 8'hff, 8'hff);
        rd(8'h10, 8'h00, 8'hff);
        $display("reset values done");
        s = 3'($urandom % 8);
        f = 16'($urandom) & 16'h7fff;
        c = 16'($urandom);
        wr(8'h8e, {5'h0, s});
        wr16(8'h9c, 16'h4000);
        wr16(8'hac, 16'h0010);
        conv(f, c);
        chk_rx(cal(f, 16'h8000, 16'h0, 16'h0), 1'b0);
        conv(16'hfff8, c);
        chk_rx(cal(c, 16'h4000, 16'h0010, 16'hf000), 1'b1);
        wr(8'h8d, 8'h02);
        conv(16'h0100, c);
        chk_rx(cal(c, 16'h4000, 16'h0010, 16'h0000), 1'b1);
        wr(8'h8d, 8'h01);
        conv(16'hffff, c);
        chk_rx(cal(16'hffff, 16'h8000, 16'h0, 16'h0), 1'b0);
        wr(8'h8d, 8'h00);
        $display("range tests done");
        wr(8'he2, 8'h02);
        wr16(8'ha6, 16'h4000);
        wr16(8'ha4, 16'h2000);
        conv(16'h4000, c);
        chk_rx(cal(16'h4000, 16'h8000, 16'h0, 16'h0), 1'b0);
        conv(16'h4001, 16'h0800);
        chk_rx(cal(16'h0800, 16'h4000, 16'h0010, 16'h2000), 1'b1);
        wr(8'he2, 8'h00);
        $display("crossover tests done");
        wr16(8'hd0, 16'h0010);
        conv(16'h1000, c);
        rd(8'h70, 8'h01, 8'h01);
        #1 check("fault", {15'h0, fault}, 16'h0);
        wr(8'he0, 8'hfe);
        repeat (4) @(posedge core_clk);
        #1 check("fault", {15'h0, fault}, 16'h1);
        wr(8'he0, 8'hff);
        $display("alarm tests done");
        wr(8'he2, 8'h01);
        low_power_trip_one <= 1'b1;
        repeat (20) @(posedge core_clk);
        #1 check("loss", {15'h0, rx_loss_output}, 16'h1);
        check("fault", {15'h0, fault}, 16'h1);
        wr(8'he2, 8'h0d);
        repeat (4) @(posedge core_clk);
        #1 check("fault", {15'h0, fault}, 16'h0);
        rd(8'h72, 8'h01, 8'h01);
        low_power_trip_one <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1 check("loss", {15'h0, rx_loss_output}, 16'h0);
        wr(8'he2, 8'h00);
        for (int i = 0; i < 2; i++) begin
            {rx_loss_in_two, rx_loss_in_one} <= 2'(1 << i);
            repeat (8) @(posedge core_clk);
            #1 check("ext loss", {15'h0, rx_loss_output}, 16'h1);
        end
        {rx_loss_in_two, rx_loss_in_one} <= 2'h0;
        repeat (8) @(posedge core_clk);
        #1 check("ext loss", {15'h0, rx_loss_output}, 16'h0);
        wr(8'he3, 8'h5a);
        wr(8'he4, 8'ha5);
        repeat (2) @(posedge core_clk);
        #1 check("trip level", {8'h0, q1}, 16'h005a);
        check("trip level", {8'h0, q2}, 16'h00a5);
        $display("loss tests done");
        wrap_up();
    end
endmodule
